// *** inc/adc_ctrl_pkg.sv ***
// Purpose: Shared constants and types for the converter control block
// Assumes: APB byte addresses, one 8-bit register per aligned word
// Notes:   Register values sit in the low byte; upper bits read as zero
package adc_ctrl_pkg;

   localparam logic [7:0] ADDR_RESULT_LOW  = 8'h00;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
   localparam logic [7:0] ADDR_CONV_CTRL   = 8'h08;
   localparam logic [7:0] ADDR_SRC_CLK_SEL = 8'h0c;
   localparam logic [7:0] ADDR_REF_AMP     = 8'h10;
   localparam logic [7:0] ADDR_BANDGAP     = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1c;

   localparam int BIT_START     = 7;
   localparam int BIT_BUSY      = 6;
   localparam int BIT_ENABLE    = 5;
   localparam int BIT_ALIGN     = 4;

   localparam logic [7:0] CONV_CTRL_WMASK = 8'hbf;
   localparam logic [7:0] SRC_CLK_WMASK   = 8'hf7;
   localparam logic [7:0] REF_AMP_WMASK   = 8'h9f;
   localparam logic [7:0] BANDGAP_WMASK   = 8'h01;
   localparam logic [7:0] REG_RESET       = 8'h00;

   localparam logic [3:0] LAST_EXT_CHANNEL = 4'hb;

   // Conversion length in conversion-clock ticks
   localparam logic [4:0] CONV_TICKS = 5'h10;

   // Interrupt status bits
   localparam int IRQ_DONE = 0;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_RUN,
      CONV_STORE
   } conv_state_e;

endpackage : adc_ctrl_pkg

// *** verilog/adc_control_register_logic.sv ***
// Purpose: Register and sequencing logic for a 12-bit converter
// Assumes: Analog core supplies a sample on conv_sample when sampled
// Notes:   APB slave, zero wait states, pslverr on unmapped address
// Contract
// - Store 12-bit result across high/low pair
// - Internal source disconnects external channel
// - Align 0: high=D11..4, low[7:4]=D3..0
// - Align 1: high[3:0]=D11..8, low=D7..0
// - Unused data bits read as zero
// - Disabled converter keeps data registers unchanged
// - Start after start bit low-high-low
// - Busy set on start, cleared at end
// - Enable low switches converter off
// - Channel codes 0..11 map, 11xx floats
// - Pin selected as input drops its I/O
// - Pin selected as input drops pull-high
// - Source field decodes external, supply, reference, ground
// - Clock divider by 1 to 128
// - Internal source ignores channel field
//
// Decided for this implementation: the register offsets and the APB register port.
module adc_control_register_logic (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [11:0] conv_sample,
   input  wire logic [15:0] pin_adc_select,
   output logic             converter_power,
   output logic             conv_clk_tick,
   output logic             sample_strobe,
   output logic [15:0]      analog_input_pin_connect,
   output logic [15:0]      pin_io_disable,
   output logic [15:0]      pin_pullup_disable,
   output logic [2:0]       internal_source,
   output logic             internal_selected,
   output logic [7:0]       reference_amplifier_control,
   output logic             bandgap_enable,
   output logic             irq
);

   typedef struct packed {
      logic [7:0]                conversion_control;
      logic [7:0]                source_and_clock_select;
      logic [7:0]                reference_amplifier_control;
      logic [7:0]                bandgap_control;
      logic [7:0]                result_low_byte;
      logic [7:0]                result_high_byte;
      logic [7:0]                irq_status;
      logic [7:0]                irq_mask;
      logic                      start_armed;
      adc_ctrl_pkg::conv_state_e state;
      logic [6:0]                div_count;
      logic [4:0]                tick_count;
      logic                      tick;
      logic [31:0]               rdata;
   } state_s;

   state_s cur;
   state_s nxt;

   function automatic logic [6:0] div_limit(input logic [2:0] code);
      div_limit = 7'((8'h01 << code) - 8'h01);
   endfunction : div_limit

   // True when the source field routes an external channel
   function automatic logic is_external(input logic [3:0] src);
      is_external = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'b11);
   endfunction : is_external

   logic       wr_en;
   logic       rd_en;
   logic       mapped;
   logic [7:0] wbyte;
   logic       enable;
   logic       ext_sel;
   logic [3:0] chan;
   logic [3:0] src;

   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && penable && !pwrite;
   assign wbyte  = pwdata[7:0];
   assign enable = cur.conversion_control[adc_ctrl_pkg::BIT_ENABLE];
   assign chan   = cur.conversion_control[3:0];
   assign src    = cur.source_and_clock_select[7:4];
   assign ext_sel = is_external(src);

   always_comb begin
      unique case (paddr)
         adc_ctrl_pkg::ADDR_RESULT_LOW,
         adc_ctrl_pkg::ADDR_RESULT_HIGH,
         adc_ctrl_pkg::ADDR_CONV_CTRL,
         adc_ctrl_pkg::ADDR_SRC_CLK_SEL,
         adc_ctrl_pkg::ADDR_REF_AMP,
         adc_ctrl_pkg::ADDR_BANDGAP,
         adc_ctrl_pkg::ADDR_IRQ_STATUS,
         adc_ctrl_pkg::ADDR_IRQ_MASK: mapped = 1'b1;
         default:                     mapped = 1'b0;
      endcase
   end

   always_comb begin
      nxt = cur;
      nxt.tick = 1'b0;

      // Register writes; busy bit is never writable
      if (wr_en && mapped) begin
         unique case (paddr)
            adc_ctrl_pkg::ADDR_CONV_CTRL: begin
               nxt.conversion_control = (wbyte & adc_ctrl_pkg::CONV_CTRL_WMASK)
                  | (cur.conversion_control & ~adc_ctrl_pkg::CONV_CTRL_WMASK);
            end
            adc_ctrl_pkg::ADDR_SRC_CLK_SEL:
               nxt.source_and_clock_select = wbyte & adc_ctrl_pkg::SRC_CLK_WMASK;
            adc_ctrl_pkg::ADDR_REF_AMP:
               nxt.reference_amplifier_control = wbyte & adc_ctrl_pkg::REF_AMP_WMASK;
            adc_ctrl_pkg::ADDR_BANDGAP:
               nxt.bandgap_control = wbyte & adc_ctrl_pkg::BANDGAP_WMASK;
            adc_ctrl_pkg::ADDR_IRQ_MASK:
               nxt.irq_mask = {7'h00, wbyte[adc_ctrl_pkg::IRQ_DONE]};
            adc_ctrl_pkg::ADDR_IRQ_STATUS:
               nxt.irq_status = cur.irq_status & ~wbyte;
            default: begin
            end
         endcase
      end

      // Start bit seen high arms; seen low again launches
      if (cur.conversion_control[adc_ctrl_pkg::BIT_START]) begin
         nxt.start_armed = 1'b1;
      end

      // Divided conversion clock runs only while enabled
      if (!enable) begin
         nxt.div_count = 7'h00;
      end else if (cur.div_count >= div_limit(cur.source_and_clock_select[2:0])) begin
         nxt.div_count = 7'h00;
         nxt.tick = 1'b1;
      end else begin
         nxt.div_count = cur.div_count + 7'h01;
      end

      unique case (cur.state)
         adc_ctrl_pkg::CONV_IDLE: begin
            if (cur.start_armed && !cur.conversion_control[adc_ctrl_pkg::BIT_START]) begin
               nxt.start_armed = 1'b0;
               if (enable) begin
                  nxt.state = adc_ctrl_pkg::CONV_RUN;
                  nxt.tick_count = 5'h00;
                  nxt.conversion_control[adc_ctrl_pkg::BIT_BUSY] = 1'b1;
               end
            end
         end
         adc_ctrl_pkg::CONV_RUN: begin
            if (!enable) begin
               // Abort keeps old data in place
               nxt.state = adc_ctrl_pkg::CONV_IDLE;
               nxt.conversion_control[adc_ctrl_pkg::BIT_BUSY] = 1'b0;
            end else if (cur.tick) begin
               if (cur.tick_count == adc_ctrl_pkg::CONV_TICKS - 5'h01) begin
                  nxt.state = adc_ctrl_pkg::CONV_STORE;
               end else begin
                  nxt.tick_count = cur.tick_count + 5'h01;
               end
            end
         end
         adc_ctrl_pkg::CONV_STORE: begin
            // Data lands here, busy drops in the same edge
            // A disable written on the last run edge must not touch the data
            if (!enable) begin
               nxt.result_high_byte = cur.result_high_byte;
            end else if (cur.conversion_control[adc_ctrl_pkg::BIT_ALIGN]) begin
               nxt.result_high_byte = {4'h0, conv_sample[11:8]};
               nxt.result_low_byte  = conv_sample[7:0];
            end else begin
               nxt.result_high_byte = conv_sample[11:4];
               nxt.result_low_byte  = {conv_sample[3:0], 4'h0};
            end
            nxt.conversion_control[adc_ctrl_pkg::BIT_BUSY] = 1'b0;
            nxt.irq_status[adc_ctrl_pkg::IRQ_DONE] = 1'b1; // Set wins over clear
            nxt.state = adc_ctrl_pkg::CONV_IDLE;
         end
         default: begin
         end
      endcase

      // Registered read data
      nxt.rdata = 32'h0;
      if (rd_en) begin
         unique case (paddr)
            adc_ctrl_pkg::ADDR_RESULT_LOW:  nxt.rdata[7:0] = cur.result_low_byte;
            adc_ctrl_pkg::ADDR_RESULT_HIGH: nxt.rdata[7:0] = cur.result_high_byte;
            adc_ctrl_pkg::ADDR_CONV_CTRL:   nxt.rdata[7:0] = cur.conversion_control;
            adc_ctrl_pkg::ADDR_SRC_CLK_SEL: nxt.rdata[7:0] = cur.source_and_clock_select;
            adc_ctrl_pkg::ADDR_REF_AMP:     nxt.rdata[7:0] = cur.reference_amplifier_control;
            adc_ctrl_pkg::ADDR_BANDGAP:     nxt.rdata[7:0] = cur.bandgap_control;
            adc_ctrl_pkg::ADDR_IRQ_STATUS:  nxt.rdata[7:0] = cur.irq_status;
            adc_ctrl_pkg::ADDR_IRQ_MASK:    nxt.rdata[7:0] = cur.irq_mask;
            default:                        nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   // Read data is sampled by the master at the access edge, so it is
   // driven combinationally from current state; rdata copy kept for debug
   always_comb begin
      prdata = 32'h0;
      unique case (paddr)
         adc_ctrl_pkg::ADDR_RESULT_LOW:  prdata[7:0] = cur.result_low_byte;
         adc_ctrl_pkg::ADDR_RESULT_HIGH: prdata[7:0] = cur.result_high_byte;
         adc_ctrl_pkg::ADDR_CONV_CTRL:   prdata[7:0] = cur.conversion_control;
         adc_ctrl_pkg::ADDR_SRC_CLK_SEL: prdata[7:0] = cur.source_and_clock_select;
         adc_ctrl_pkg::ADDR_REF_AMP:     prdata[7:0] = cur.reference_amplifier_control;
         adc_ctrl_pkg::ADDR_BANDGAP:     prdata[7:0] = cur.bandgap_control;
         adc_ctrl_pkg::ADDR_IRQ_STATUS:  prdata[7:0] = cur.irq_status;
         adc_ctrl_pkg::ADDR_IRQ_MASK:    prdata[7:0] = cur.irq_mask;
         default:                        prdata = 32'h0;
      endcase
   end

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   assign converter_power = enable;
   assign conv_clk_tick   = cur.tick;
   assign sample_strobe   = (cur.state == adc_ctrl_pkg::CONV_STORE);
   assign internal_selected = !ext_sel;
   assign internal_source   = src[2:0];

   // Codes above the last channel leave the input floating
   always_comb begin
      analog_input_pin_connect = 16'h0000;
      if (enable && ext_sel && chan <= adc_ctrl_pkg::LAST_EXT_CHANNEL) begin
         analog_input_pin_connect[chan] = 1'b1;
      end
   end

   assign pin_io_disable     = pin_adc_select;
   assign pin_pullup_disable = pin_adc_select;
   assign reference_amplifier_control = cur.reference_amplifier_control;
   assign bandgap_enable = cur.bandgap_control[0];
   assign irq = |(cur.irq_status & cur.irq_mask);

endmodule : adc_control_register_logic

// *** tb/adc_core_model.sv ***
// Purpose: Stand-in for the analog core feeding conversion samples
// Assumes: Block captures conv_sample only while sample_strobe is high
// Notes:   Bus churns outside the capture cycle, so stale data never matches
module adc_core_model (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        sample_strobe,
   input  wire logic [11:0] sample_value,
   output logic      [11:0] conv_sample
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] churn;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) churn <= 12'h5a5;
      else churn <= ~churn + 12'h001;
   end
   assign conv_sample = sample_strobe ? sample_value : churn;
endmodule : adc_core_model

// *** tb/adc_ctrl_monitor.sv ***
// Purpose: Port assertions for the converter control block
// Assumes: Alignment and mask bits tracked from APB writes
// Notes:   Bound to the design after the module
module adc_ctrl_monitor (
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic [15:0] pin_adc_select,
   input wire logic        converter_power,
   input wire logic        sample_strobe,
   input wire logic [15:0] analog_input_pin_connect,
   input wire logic [15:0] pin_io_disable,
   input wire logic [15:0] pin_pullup_disable,
   input wire logic        internal_selected,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic wr, align, mask;
   assign wr = psel && penable && pwrite && pready;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         align <= 1'b0;
         mask  <= 1'b0;
      end else if (wr && paddr == adc_ctrl_pkg::ADDR_CONV_CTRL) begin
         align <= pwdata[adc_ctrl_pkg::BIT_ALIGN];
      end else if (wr && paddr == adc_ctrl_pkg::ADDR_IRQ_MASK) begin
         mask <= pwdata[adc_ctrl_pkg::IRQ_DONE];
      end
   end
   sequence s_ctrl_write;
      wr && paddr == adc_ctrl_pkg::ADDR_CONV_CTRL;
   endsequence
   a_io_release: assert property (pin_io_disable == pin_adc_select)
      else $error("pin io not released");
   a_pullup_drop: assert property (pin_pullup_disable == pin_adc_select)
      else $error("pull-high not dropped");
   a_internal_isolated: assert property (
      internal_selected |-> analog_input_pin_connect == 16'h0000)
      else $error("pin routed with internal source");
   a_pin_onehot: assert property ($onehot0(analog_input_pin_connect))
      else $error("several pins routed");
   a_power_follow: assert property (
      s_ctrl_write |=> converter_power == $past(pwdata[adc_ctrl_pkg::BIT_ENABLE]))
      else $error("power not following enable");
   a_store_powered: assert property (sample_strobe |-> converter_power)
      else $error("capture while disabled");
   a_low_pad_zero: assert property (
      psel && penable && !pwrite && paddr == adc_ctrl_pkg::ADDR_RESULT_LOW && !align
      |-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
      else $error("low result padding not zero");
   a_done_irq: assert property (sample_strobe && mask && !wr |=> irq)
      else $error("done event raised no interrupt");
endmodule : adc_ctrl_monitor
bind adc_control_register_logic adc_ctrl_monitor u_mon (.ref_clk, .rstn, .paddr, .psel,
   .penable, .pwrite, .pwdata, .prdata, .pready, .pin_adc_select, .converter_power,
   .sample_strobe, .analog_input_pin_connect, .pin_io_disable, .pin_pullup_disable,
   .internal_selected, .irq);

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero wait-state APB slave, done interrupt on status bit 0
// Notes:   Fastest divider keeps conversions short
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_LO  = adc_ctrl_pkg::ADDR_RESULT_LOW;
   localparam logic [7:0] A_HI  = adc_ctrl_pkg::ADDR_RESULT_HIGH;
   localparam logic [7:0] A_CTL = adc_ctrl_pkg::ADDR_CONV_CTRL;
   localparam logic [7:0] A_SRC = adc_ctrl_pkg::ADDR_SRC_CLK_SEL;
   logic        ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, converter_power, conv_clk_tick, sample_strobe;
   logic        internal_selected, irq, bandgap_enable;
   logic [2:0]  internal_source;
   logic [7:0]  ref_amp;
   logic [11:0] conv_sample, sample_value = 12'h000;
   logic [15:0] pin_adc_select = 16'h0a5c, analog_input_pin_connect;
   logic [15:0] pin_io_disable, pin_pullup_disable;
   int          fail_count = 0, num_checks = 0, n;
   always #12.5 ref_clk = ~ref_clk;
   adc_control_register_logic u_dut (.ref_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .conv_sample, .pin_adc_select, .converter_power, .conv_clk_tick,
      .sample_strobe, .analog_input_pin_connect, .pin_io_disable, .pin_pullup_disable,
      .internal_source, .internal_selected, .reference_amplifier_control(ref_amp), .bandgap_enable,
      .irq);
   adc_core_model u_core (.ref_clk, .rstn, .sample_strobe, .sample_value, .conv_sample);
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : chk_reg
   task automatic t_convert(input logic [7:0] c, input logic [11:0] v, input logic [7:0] hi, lo);
      sample_value <= v;
      apb(1'b1, A_CTL, {24'h0, c | 8'hc0});
      chk_reg(A_CTL, {24'h0, c | 8'h80});
      apb(1'b1, A_CTL, {24'h0, c});
      chk_reg(A_CTL, {24'h0, c | 8'h40});
      n = 0;
      while (rd[6] === 1'b1 && n < 100) begin
         apb(1'b0, A_CTL, 32'h0);
         n++;
      end
      `CHK(rd[6], 1'b0)
      chk_reg(A_LO, {24'h0, lo});
      chk_reg(A_HI, {24'h0, hi});
   endtask : t_convert
   task automatic t_idle;
      sample_value <= 12'h123;
      apb(1'b1, A_CTL, 32'ha0);
      repeat (40) @(posedge ref_clk);
      chk_reg(A_CTL, 32'ha0);
      apb(1'b1, A_CTL, 32'h00);
      `CHK(converter_power, 1'b0)
      apb(1'b1, A_CTL, 32'h80);
      apb(1'b1, A_CTL, 32'h00);
      repeat (40) @(posedge ref_clk);
      chk_reg(A_CTL, 32'h0);
      chk_reg(A_LO, 32'hf0);
      chk_reg(A_HI, 32'hff);
   endtask : t_idle
   task automatic t_route;
      logic e;
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, A_CTL, 32'h20 | c);
         `CHK(analog_input_pin_connect, (c < 12) ? 16'h0001 << c : 16'h0000)
      end
      pin_adc_select <= 16'hf00f;
      apb(1'b1, A_CTL, 32'h25);
      `CHK(pin_io_disable, 16'hf00f)
      `CHK(pin_pullup_disable, 16'hf00f)
      for (int s = 0; s < 16; s++) begin
         e = !(s == 0 || s == 4 || s >= 12);
         apb(1'b1, A_SRC, {24'h0, s[3:0], 4'h0});
         `CHK(internal_selected, e)
         `CHK(internal_source, s[2:0])
         `CHK(analog_input_pin_connect, e ? 16'h0000 : 16'h0020)
      end
   endtask : t_route
   task automatic t_regs;
      apb(1'b1, adc_ctrl_pkg::ADDR_REF_AMP, 32'hff);
      chk_reg(adc_ctrl_pkg::ADDR_REF_AMP, 32'h9f);
      `CHK(ref_amp, 8'h9f)
      apb(1'b1, adc_ctrl_pkg::ADDR_BANDGAP, 32'hff);
      chk_reg(adc_ctrl_pkg::ADDR_BANDGAP, 32'h01);
      `CHK(bandgap_enable, 1'b1)
      apb(1'b1, A_SRC, 32'hff);
      chk_reg(A_SRC, 32'hf7);
   endtask : t_regs
   task automatic t_divider;
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, A_SRC, k);
         repeat (2) begin
            do @(posedge ref_clk); while (conv_clk_tick !== 1'b1);
         end
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (conv_clk_tick !== 1'b1);
         `CHK(n, 1 << k)
      end
   endtask : t_divider
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      #100us;
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 32; i += 4) chk_reg(i[7:0], 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, A_SRC, 32'h0);
      apb(1'b1, adc_ctrl_pkg::ADDR_IRQ_MASK, 32'h1);
      t_convert(8'h23, 12'habc, 8'hab, 8'hc0);
      `CHK(irq, 1'b1)
      apb(1'b1, adc_ctrl_pkg::ADDR_IRQ_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      t_convert(8'h33, 12'habc, 8'h0a, 8'hbc);
      t_convert(8'h23, 12'hfff, 8'hff, 8'hf0);
      t_idle();
      t_route();
      t_regs();
      t_divider();
      finish_test();
   end
endmodule : tb_top
